// [hdl/msl_ctrl.sv]
// Monitor run/lock control register bank with AHB-Lite slave.
// Assumes one AHB-Lite master, single word transfers, hclk at 100 MHz.
// Summary of operation
// RL1 - Setting run starts monitoring and PWM control from programmed values.
// RL2 - Measurement registers other than tach do not update before run is set.
// RL3 - Run at zero uses built-in default limits, not programmed ones.
// RL4 - Changing run leaves limit and parameter registers untouched.
// RL5 - Once freeze is set, writes to run are ignored.
// RL6 - Run at zero drives full duty: 255 clocks high, 1 low.
// RL7 - Freeze makes limit and parameter registers read-only until power-off.
// RL8 - Freeze is sticky; writes cannot clear it.
// RL9 - Ready flag is read-only and always reads one.
// RL10 - Force bit drives all PWM outputs to full duty regardless of freeze.
// RL11 - Readings are invalid for up to 82 ms after run is set.
// RL12 - Run at zero: no limit monitoring, readings not valid.
// RL13 - Tachometer readings always report measured timing, even with run zero.
// RL14 - Event status bits set only while run is one.
// RL15 - Run alone never blocks limit or parameter writes.
// RL16 - Software should program limits before setting run.
// RL17 - Bits 4 to 7 read zero and ignore writes.
// RL18 - Run zero and not manual: duty register reads all ones.
// RL19 - Force takes priority over automatic and manual duty.
`timescale 1ns/100ps
module msl_ctrl #(
    parameter int STARTUP_CYC = msl_pkg::STARTUP_CYC
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, active low
    input wire logic hsel, // Slave select
    input wire logic [31:0] haddr, // Address
    input wire logic [1:0] htrans, // Transfer type
    input wire logic hwrite, // Write
    input wire logic [2:0] hsize, // Size
    input wire logic [31:0] hwdata, // Write data
    input wire logic hready, // Bus ready
    output logic [31:0] hrdata, // Read data
    output logic hreadyout, // Slave ready
    output logic hresp, // Response
    input wire logic [15:0] tach_count, // Measured tach period
    input wire logic [7:0] meas_value, // Measured value
    input wire logic meas_strobe, // New measurement
    input wire logic [7:0] auto_duty, // Automatic fan duty
    input wire logic [7:0] event_raw, // Raw limit violations
    output logic pwm_out_q, // PWM pin
    output logic monitor_en_q, // Monitoring active
    output logic [7:0] limit_eff_q, // Limit in use
    output logic readings_valid_q // Readings valid
);
    // ========================================================
    // Bus address phase capture
    logic wr_pend_q;
    logic rd_pend_q;
    logic [7:0] addr_q;
    logic [31:0] hrdata_q;
    logic access;

    assign access = hsel && hready && htrans[1];
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = hrdata_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            wr_pend_q <= 1'b0;
            rd_pend_q <= 1'b0;
            addr_q <= 8'h00;
        end
        else if (hready)
        begin
            wr_pend_q <= access && hwrite;
            rd_pend_q <= access && !hwrite;
            addr_q <= haddr[7:0];
        end
    end

    function automatic logic is_wr(input logic pend, input logic [7:0] a,
                                   input logic [7:0] want);
        return pend && (a == want);
    endfunction : is_wr

    // ========================================================
    // Control bits
    logic run_q;
    logic freeze_q;
    logic force_q;
    logic manual_q;
    logic [7:0] limit_q;
    logic [7:0] man_duty_q;
    msl_pkg::msl_ctrl_t ctrl;

    assign ctrl = '{run: run_q, freeze: freeze_q, force_full: force_q,
                    manual: manual_q};

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            run_q <= msl_pkg::RUN_CTRL_RST[msl_pkg::BIT_RUN];
        else if (is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_RUN_CTRL) &&
                 !freeze_q)
            run_q <= hwdata[msl_pkg::BIT_RUN]; // [RL5]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            freeze_q <= msl_pkg::RUN_CTRL_RST[msl_pkg::BIT_FREEZE];
        else if (is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_RUN_CTRL) &&
                 hwdata[msl_pkg::BIT_FREEZE])
            freeze_q <= 1'b1; // [RL8]
    end

    // Force stays writable after freeze, so a hot system can still go full
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            force_q <= msl_pkg::RUN_CTRL_RST[msl_pkg::BIT_FORCE];
        else if (is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_RUN_CTRL))
            force_q <= hwdata[msl_pkg::BIT_FORCE]; // [RL10]
    end

    // Limit and manual duty are frozen only by freeze, never by run
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            limit_q <= msl_pkg::LIMIT_RST;
        else if (is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_LIMIT) &&
                 !freeze_q)
            limit_q <= hwdata[7:0]; // [RL7] [RL15] [RL4]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            man_duty_q <= msl_pkg::DUTY_RST;
            manual_q <= 1'b0;
        end
        else if (is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_MAN_DUTY) &&
                 !freeze_q)
        begin
            man_duty_q <= hwdata[7:0]; // [RL7]
            manual_q <= hwdata[8];
        end
    end

    // ========================================================
    // Effective limit and monitoring
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            limit_eff_q <= msl_pkg::DEFAULT_LIMIT;
            monitor_en_q <= 1'b0;
        end
        else
        begin
            limit_eff_q <= ctrl.run ? limit_q
                                    : msl_pkg::DEFAULT_LIMIT; // [RL1] [RL3]
            monitor_en_q <= ctrl.run; // [RL12] [RL1]
        end
    end

    // ========================================================
    // Reading, tach and event status
    logic [7:0] reading_q;
    logic [15:0] tach_q;
    logic [7:0] status_q;
    logic status_rd;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            reading_q <= 8'h00;
        else if (meas_strobe && ctrl.run)
            reading_q <= meas_value; // [RL2]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            tach_q <= 16'h0000;
        else
            tach_q <= tach_count; // [RL13]
    end

    assign status_rd = is_wr(rd_pend_q, addr_q, msl_pkg::ADDR_STATUS);

    // Set wins over read-clear, so an event in the clearing cycle stays
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            status_q <= 8'h00;
        else
            status_q <= (status_rd ? 8'h00 : status_q) |
                        (ctrl.run ? event_raw : 8'h00); // [RL14]
    end

    // ========================================================
    // PWM duty selection
    logic [7:0] duty_sel;
    logic [7:0] duty_now;
    logic [7:0] cur_duty_rd;

    always_comb
    begin
        if (ctrl.force_full || !ctrl.run)
            duty_sel = msl_pkg::DUTY_FULL; // [RL19] [RL10] [RL6]
        else if (ctrl.manual)
            duty_sel = man_duty_q;
        else
            duty_sel = auto_duty;
    end

    msl_pwm u_pwm (
        .hclk(hclk),
        .hresetn(hresetn),
        .duty(duty_sel),
        .pwm_q(pwm_out_q),
        .duty_q(duty_now)
    );

    msl_startup #(.STARTUP_CYC(STARTUP_CYC)) u_startup (
        .hclk(hclk),
        .hresetn(hresetn),
        .run(run_q),
        .valid_q(readings_valid_q)
    );

    assign cur_duty_rd = (!ctrl.run && !ctrl.manual) ? msl_pkg::DUTY_FULL
                                                     : duty_now; // [RL18]

    // ========================================================
    // Read data
    logic [31:0] rd_mux;

    always_comb
    begin
        rd_mux = 32'h00000000;
        unique case (haddr[7:0])
            msl_pkg::ADDR_RUN_CTRL:
            begin
                rd_mux[msl_pkg::BIT_RUN] = run_q;
                rd_mux[msl_pkg::BIT_FREEZE] = freeze_q;
                rd_mux[msl_pkg::BIT_READY] = 1'b1; // [RL9] [RL17]
                rd_mux[msl_pkg::BIT_FORCE] = force_q;
            end
            msl_pkg::ADDR_LIMIT: rd_mux[7:0] = limit_q;
            msl_pkg::ADDR_MAN_DUTY: rd_mux[8:0] = {manual_q, man_duty_q};
            msl_pkg::ADDR_CUR_DUTY: rd_mux[7:0] = cur_duty_rd;
            msl_pkg::ADDR_STATUS: rd_mux[7:0] = status_q;
            msl_pkg::ADDR_TACH: rd_mux[15:0] = tach_q;
            msl_pkg::ADDR_READING: rd_mux[8:0] = {readings_valid_q, reading_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            hrdata_q <= 32'h00000000;
        else if (access && !hwrite)
            hrdata_q <= rd_mux;
    end

    // ========================================================
    // Checks
    // Cycles spent stopped, saturating; spans two PWM periods
    logic [8:0] stop_cnt_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            stop_cnt_q <= 9'h000;
        else if (run_q)
            stop_cnt_q <= 9'h000;
        else if (stop_cnt_q != 9'h1ff)
            stop_cnt_q <= stop_cnt_q + 9'h001;
    end

    sequence s_ctrl_write;
        is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_RUN_CTRL);
    endsequence

    sequence s_ctrl_write_open;
        is_wr(wr_pend_q, addr_q, msl_pkg::ADDR_RUN_CTRL) && !freeze_q;
    endsequence

    sequence s_ctrl_read;
        access && !hwrite && (haddr[7:0] == msl_pkg::ADDR_RUN_CTRL);
    endsequence

    sequence s_long_stop;
        stop_cnt_q == 9'h1ff;
    endsequence

    a_freeze_sticky: assert property ( // [RL8]
        @(posedge hclk) disable iff (!hresetn)
        freeze_q |=> freeze_q)
        else $error("freeze bit cleared");
    a_run_locked: assert property ( // [RL5]
        @(posedge hclk) disable iff (!hresetn)
        freeze_q && $past(freeze_q) |-> $stable(run_q))
        else $error("run changed while frozen");
    a_limit_frozen: assert property ( // [RL7]
        @(posedge hclk) disable iff (!hresetn)
        freeze_q && $past(freeze_q) |-> $stable(limit_q))
        else $error("limit changed while frozen");
    a_default_limit: assert property ( // [RL3]
        @(posedge hclk) disable iff (!hresetn)
        !run_q |=> limit_eff_q == msl_pkg::DEFAULT_LIMIT)
        else $error("programmed limit used while stopped");
    a_no_status: assert property ( // [RL14]
        @(posedge hclk) disable iff (!hresetn)
        !run_q && status_rd |=> status_q == 8'h00)
        else $error("status set while stopped");
    a_reading_hold: assert property ( // [RL2]
        @(posedge hclk) disable iff (!hresetn)
        !run_q |=> $stable(reading_q))
        else $error("reading updated while stopped");
    a_force_full: assert property ( // [RL19]
        @(posedge hclk) disable iff (!hresetn)
        force_q |-> duty_sel == msl_pkg::DUTY_FULL)
        else $error("force not at full duty");
    a_tach_live: assert property ( // [RL13]
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> tach_q == $past(tach_count))
        else $error("tach not tracking");
    a_run_write: assert property ( // [RL1] [RL5]
        @(posedge hclk) disable iff (!hresetn)
        s_ctrl_write_open |=> run_q == $past(hwdata[msl_pkg::BIT_RUN]))
        else $error("run write not taken");
    a_force_write: assert property ( // [RL10]
        @(posedge hclk) disable iff (!hresetn)
        s_ctrl_write |=> force_q == $past(hwdata[msl_pkg::BIT_FORCE]))
        else $error("force write not taken");
    a_ready_read: assert property ( // [RL9] [RL17]
        @(posedge hclk) disable iff (!hresetn)
        s_ctrl_read |=> hrdata[msl_pkg::BIT_READY] && hrdata[7:4] == 4'h0)
        else $error("ready or reserved bits read wrong");
    a_valid_stop: assert property ( // [RL12]
        @(posedge hclk) disable iff (!hresetn)
        !run_q |=> !readings_valid_q)
        else $error("readings valid while stopped");
    a_monitor_follow: assert property ( // [RL1] [RL12]
        @(posedge hclk) disable iff (!hresetn)
        1'b1 |=> monitor_en_q == $past(run_q))
        else $error("monitoring does not follow run");
    a_status_keep: assert property ( // [RL14]
        @(posedge hclk) disable iff (!hresetn)
        run_q |=>
            (status_q & $past(event_raw)) == $past(event_raw))
        else $error("violation not held in status");
    a_stop_full: assert property ( // [RL6]
        @(posedge hclk) disable iff (!hresetn)
        s_long_stop |-> duty_now == msl_pkg::DUTY_FULL)
        else $error("duty not full while stopped");
endmodule : msl_ctrl

// [hdl/msl_pkg.sv]
// Package for the monitor run/lock control block.
// Assumes a single 100 MHz clock domain and an AHB-Lite register bus.
package msl_pkg;

    // ========================================================
    // Register map (byte addresses, word aligned)
    localparam logic [7:0] ADDR_RUN_CTRL = 8'h00;
    localparam logic [7:0] ADDR_LIMIT = 8'h04;
    localparam logic [7:0] ADDR_MAN_DUTY = 8'h08;
    localparam logic [7:0] ADDR_CUR_DUTY = 8'h0c;
    localparam logic [7:0] ADDR_STATUS = 8'h10;
    localparam logic [7:0] ADDR_TACH = 8'h14;
    localparam logic [7:0] ADDR_READING = 8'h18;
    localparam logic [7:0] ADDR_EVENT_IN = 8'h1c;

    // ========================================================
    // Run control fields
    localparam int BIT_RUN = 0;
    localparam int BIT_FREEZE = 1;
    localparam int BIT_READY = 2;
    localparam int BIT_FORCE = 3;
    localparam logic [7:0] RUN_CTRL_RST = 8'h00;

    // ========================================================
    // Reset values and defaults
    localparam logic [7:0] LIMIT_RST = 8'h00;
    localparam logic [7:0] DEFAULT_LIMIT = 8'h7f;
    localparam logic [7:0] DUTY_FULL = 8'hff;
    localparam logic [7:0] DUTY_RST = 8'h00;
    localparam logic [7:0] PWM_PERIOD_LAST = 8'hff;

    // ========================================================
    // Timing
    localparam int CLK_MHZ = 100;
    localparam int STARTUP_MS = 82;
    localparam int STARTUP_CYC = STARTUP_MS * 1000 * CLK_MHZ;
    localparam int STARTUP_W = 24;

    typedef struct packed {
        logic run;
        logic freeze;
        logic force_full;
        logic manual;
    } msl_ctrl_t;

endpackage : msl_pkg

// [hdl/msl_pwm.sv]
// PWM generator: 256 clocks per period, duty 8'hff gives 255 high, 1 low.
// Assumes duty is sampled at the start of each period.
`timescale 1ns/100ps
module msl_pwm (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, active low
    input wire logic [7:0] duty, // Requested duty
    output logic pwm_q, // PWM out
    output logic [7:0] duty_q // Duty in force this period
);
    logic [7:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 8'h00;
        else
            cnt_q <= cnt_q + 8'h01;
    end

    // Latch duty at period start to avoid glitches
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            duty_q <= msl_pkg::DUTY_FULL;
        else if (cnt_q == msl_pkg::PWM_PERIOD_LAST)
            duty_q <= duty;
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            pwm_q <= 1'b0;
        else
            pwm_q <= (cnt_q < duty_q);
    end

    a_pwm_full_low: assert property ( // [RL6]
        @(posedge hclk) disable iff (!hresetn)
        (duty_q == 8'hff && cnt_q == 8'hff && $past(duty_q) == 8'hff)
        |=> !pwm_q)
        else $error("full duty lacks its one low clock");
endmodule : msl_pwm

// [hdl/msl_startup.sv]
// Start-up timer: readings are invalid for a while after run is set.
// Assumes run comes from a register on the same clock.
`timescale 1ns/100ps
module msl_startup #(
    parameter int STARTUP_CYC = msl_pkg::STARTUP_CYC
) (
    input wire logic hclk, // Clock
    input wire logic hresetn, // Async reset, active low
    input wire logic run, // Run enable
    output logic valid_q // Readings valid
);
    localparam logic [23:0] LAST = 24'(STARTUP_CYC - 1);
    logic [23:0] cnt_q;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            cnt_q <= 24'h000000;
        else if (!run)
            cnt_q <= 24'h000000;
        else if (!valid_q)
            cnt_q <= cnt_q + 24'h000001; // [RL11]
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
            valid_q <= 1'b0;
        else if (!run)
            valid_q <= 1'b0; // [RL12]
        else if (cnt_q == LAST)
            valid_q <= 1'b1; // [RL11]
    end

    a_startup_hold: assert property ( // [RL11]
        @(posedge hclk) disable iff (!hresetn)
        $rose(run) |-> !valid_q [*8])
        else $error("readings valid too soon after run");
endmodule : msl_startup

// [tb/msl_tb.sv]
// Self-checking bench for the monitor run/lock control register bank.
// Assumes zero-wait AHB-Lite slave and a shortened start-up count.
`timescale 1ns/100ps
module tb;
    localparam int SCYC = 20;
    logic hclk, hresetn, hsel, hwrite, hready, hresp, meas_strobe;
    logic [31:0] haddr, hwdata, hrdata;
    logic [1:0] htrans;
    logic [2:0] hsize;
    logic [15:0] tach_count;
    logic [7:0] meas_value, auto_duty, event_raw, limit_eff_q;
    logic pwm_out_q, monitor_en_q, readings_valid_q;
    int failures = 0;
    int comparisons = 0;
    int cycles = 0;
    int n;

    msl_ctrl #(.STARTUP_CYC(SCYC)) u_dut (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hready), .hrdata(hrdata), .hreadyout(hready),
        .hresp(hresp), .tach_count(tach_count), .meas_value(meas_value),
        .meas_strobe(meas_strobe), .auto_duty(auto_duty),
        .event_raw(event_raw), .pwm_out_q(pwm_out_q),
        .monitor_en_q(monitor_en_q), .limit_eff_q(limit_eff_q),
        .readings_valid_q(readings_valid_q)
    );

    initial
    begin
        hclk = 1'b0;
        forever #5 hclk = ~hclk;
    end

    // =========================================================
    // Hang guard: whole run is a few thousand cycles
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            failures++;
            end_of_test();
        end
    end

    task chk(input string name, input logic [31:0] exp,
             input logic [31:0] got);
        comparisons++;
        if (got !== exp)
        begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            failures++;
        end
    endtask : chk

    // Single word transfer; data taken at the edge ending the data phase
    task xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
              output logic [31:0] rd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        hsize <= 3'h2;
        do @(posedge hclk); while (hready !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        do @(posedge hclk); while (hready !== 1'b1);
        rd = hrdata;
        chk("hresp", 32'h0, {31'h0, hresp});
    endtask : xfer

    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        xfer(1'b1, a, d, r);
    endtask : wr

    task rd(input string name, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] r;
        xfer(1'b0, a, 32'h0, r);
        chk(name, exp, r);
    endtask : rd

    // High count of the pin over one 256-clock window
    task pwm_high(input logic [31:0] exp);
        n = 0;
        repeat (256)
        begin
            @(posedge hclk);
            #1;
            if (pwm_out_q === 1'b1)
                n++;
        end
        chk("pwm_high", exp, n);
    endtask : pwm_high

    task settle;
        repeat (520) @(posedge hclk);
    endtask : settle

    task end_of_test;
        if (failures == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : end_of_test

    // =========================================================
    // Main sequence
    initial
    begin
        hresetn = 1'b0;
        {hsel, hwrite, meas_strobe} = 3'h0;
        haddr = 32'h0;
        hwdata = 32'h0;
        htrans = 2'h0;
        hsize = 3'h2;
        tach_count = 16'h1234;
        meas_value = 8'h3c;
        auto_duty = 8'h40;
        event_raw = 8'h00;
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        rd("run_ctrl", msl_pkg::ADDR_RUN_CTRL, 32'h04);
        rd("unmapped", 8'h3c, 32'h0);
        wr(msl_pkg::ADDR_LIMIT, 32'h33);
        rd("limit", msl_pkg::ADDR_LIMIT, 32'h33);
        chk("limit_eff", 32'h7f, {24'h0, limit_eff_q});
        chk("monitor_en", 32'h0, {31'h0, monitor_en_q});
        rd("cur_duty", msl_pkg::ADDR_CUR_DUTY, 32'hff);
        pwm_high(32'd255);
        event_raw <= 8'ha5;
        @(posedge hclk);
        meas_strobe <= 1'b1;
        @(posedge hclk);
        meas_strobe <= 1'b0;
        rd("status", msl_pkg::ADDR_STATUS, 32'h0);
        rd("reading", msl_pkg::ADDR_READING, 32'h0);
        rd("tach", msl_pkg::ADDR_TACH, 32'h1234);
        // Reserved bits written as ones must not stick; ready reads one regardless
        wr(msl_pkg::ADDR_RUN_CTRL, 32'hf5);
        chk("valid_early", 32'h0, {31'h0, readings_valid_q});
        n = 0;
        while (readings_valid_q !== 1'b1 && n < 200)
        begin
            @(posedge hclk);
            n++;
        end
        chk("valid_delay", 32'h1,
            {31'h0, n >= SCYC - 4 && n <= SCYC + 4});
        rd("run_ctrl", msl_pkg::ADDR_RUN_CTRL, 32'h05);
        chk("monitor_en", 32'h1, {31'h0, monitor_en_q});
        chk("limit_eff", 32'h33, {24'h0, limit_eff_q});
        wr(msl_pkg::ADDR_LIMIT, 32'h44);
        rd("limit", msl_pkg::ADDR_LIMIT, 32'h44);
        rd("status", msl_pkg::ADDR_STATUS, 32'ha5);
        meas_value <= 8'h5a;
        meas_strobe <= 1'b1;
        @(posedge hclk);
        meas_strobe <= 1'b0;
        repeat (2) @(posedge hclk);
        rd("reading", msl_pkg::ADDR_READING, 32'h15a);
        rd("tach", msl_pkg::ADDR_TACH, 32'h1234);
        settle();
        rd("cur_duty", msl_pkg::ADDR_CUR_DUTY, 32'h40);
        pwm_high(32'd64);
        wr(msl_pkg::ADDR_MAN_DUTY, 32'h108);
        settle();
        rd("cur_duty", msl_pkg::ADDR_CUR_DUTY, 32'h08);
        pwm_high(32'd8);
        wr(msl_pkg::ADDR_RUN_CTRL, 32'h09);
        settle();
        rd("cur_duty", msl_pkg::ADDR_CUR_DUTY, 32'hff);
        pwm_high(32'd255);
        wr(msl_pkg::ADDR_RUN_CTRL, 32'h00);
        repeat (3) @(posedge hclk);
        rd("limit", msl_pkg::ADDR_LIMIT, 32'h44);
        chk("limit_eff", 32'h7f, {24'h0, limit_eff_q});
        chk("monitor_en", 32'h0, {31'h0, monitor_en_q});
        chk("valid_stop", 32'h0, {31'h0, readings_valid_q});
        wr(msl_pkg::ADDR_RUN_CTRL, 32'h03);
        wr(msl_pkg::ADDR_RUN_CTRL, 32'h00);
        rd("run_ctrl", msl_pkg::ADDR_RUN_CTRL, 32'h07);
        wr(msl_pkg::ADDR_LIMIT, 32'h55);
        rd("limit", msl_pkg::ADDR_LIMIT, 32'h44);
        wr(msl_pkg::ADDR_RUN_CTRL, 32'h08);
        rd("run_ctrl", msl_pkg::ADDR_RUN_CTRL, 32'h0f);
        settle();
        pwm_high(32'd255);
        end_of_test();
    end
endmodule : tb
